// ---- pkg/ddr2_cmd_regs.svh ----
`ifndef DDR2_CMD_REGS_SVH
`define DDR2_CMD_REGS_SVH
// Address bit positions
`define AP_BIT        10
`define RTT_HI_BIT    6
`define RTT_LO_BIT    2
// Extended register 1 select on bank inputs
`define EMR1_BANK     3'h1
// Reset values
`define AL_RESET      3'h0
`define RTT_RESET     2'h0
// Largest supported additive latency
`define AL_MAX        3'h6
// Timing counts in clocks of 40 ns
`define CLK_PERIOD_NS 40
`define TMOD_MIN_NS   0
`define TMOD_MAX_NS   12
`define TMOD_MAX_CYC  ((`TMOD_MAX_NS) / (`CLK_PERIOD_NS) < 1 ? 1 : \
                       (`TMOD_MAX_NS) / (`CLK_PERIOD_NS))
`endif

// ---- pkg/ddr2_cmd_pkg.sv ----
package ddr2_cmd_pkg;
   typedef enum logic [3:0] {
      CMD_NOP      = 4'h0,
      CMD_ACT      = 4'h1,
      CMD_RD       = 4'h2,
      CMD_WR       = 4'h3,
      CMD_PRE      = 4'h4,
      CMD_PREA     = 4'h5,
      CMD_REF      = 4'h6,
      CMD_SRE      = 4'h7,
      CMD_MRS      = 4'h8,
      CMD_DESEL    = 4'h9
   } cmd_t;

   typedef enum logic [1:0] {
      ST_NORMAL    = 2'h0,
      ST_SELF_REF  = 2'h1
   } pwr_t;

   typedef struct packed {
      logic [15:0] bank;
      logic [3:0]  op;
   } trace_t;
endpackage : ddr2_cmd_pkg

// ---- pkg/trace_if.sv ----
`timescale 1ns/100ps
interface trace_if #(parameter int W = 20);
   logic         in_valid;
   logic         in_ready;
   logic [W-1:0] in_data;
   logic         out_valid;
   logic         out_ready;
   logic [W-1:0] out_data;
   modport writer (output in_valid, output in_data, input in_ready,
                   input out_valid, input out_data, output out_ready);
   modport fifo   (input in_valid, input in_data, output in_ready,
                   output out_valid, output out_data, input out_ready);
endinterface : trace_if

// ---- src/ddr2_trace_fifo.sv ----
`timescale 1ns/100ps
module ddr2_trace_fifo #(
   parameter int W     = 20,
   parameter int DEPTH = 8
)(
   input  wire logic i_clk,        // System clock
   input  wire logic i_rst,        // Async reset, high
   trace_if.fifo     port          // Both handshake sides
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0]  wr;
      logic [AW:0]  rd;
      logic [W-1:0] dout;
      logic         dvalid;
   } fstate_t;

   logic [W-1:0] mem [DEPTH];
   fstate_t      st;
   fstate_t      next_st;
   logic         full;
   logic         empty;
   logic         push;
   logic         pop;

   assign full  = (st.wr[AW] != st.rd[AW]) && (st.wr[AW-1:0] == st.rd[AW-1:0]);
   assign empty = (st.wr == st.rd);
   assign port.in_ready  = !full;
   assign port.out_valid = st.dvalid;
   assign port.out_data  = st.dout;
   assign push = port.in_valid && !full;
   assign pop  = !empty && (!st.dvalid || port.out_ready);

   always_comb
   begin
      next_st = st;
      if (push)
         next_st.wr = st.wr + 1'b1;
      if (port.out_ready)
         next_st.dvalid = 1'b0;
      if (pop)
      begin
         next_st.rd     = st.rd + 1'b1;
         next_st.dout   = mem[st.rd[AW-1:0]];
         next_st.dvalid = 1'b1;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (push)
         mem[st.wr[AW-1:0]] <= port.in_data;
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         st <= '0;
      else
         st <= next_st;
   end

   no_overflow_a: assert property (@(posedge i_clk) disable iff (i_rst)
      full |=> st.wr == $past(st.wr))
      else $error("fifo written while full");
   cov_full: cover property (@(posedge i_clk) disable iff (i_rst) full);
endmodule : ddr2_trace_fifo

// ---- src/ddr2_cmd_logic.sv ----
`timescale 1ns/100ps
`include "ddr2_cmd_regs.svh"
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// [RL1] Read or write accepted the cycle after activating that bank.
// [RL2] Early column commands need additive latency 0 to 6. I_AL is not checked; a value of 7 is used as given.
// [RL3] Controller precharges before reactivating; honours row cycle timings.
// [RL4] Controller issues at most four activates per rolling window.
// [RL5] Precharge-all needs one extra clock before next activate.
// [RL6] Read decode: bank, column A0-A9, A10 selects auto-precharge.
// [RL7] Write decode likewise; without auto-precharge row stays open.
// [RL8] Read auto-precharge starts AL plus BL/2 clocks after command.
// [RL9] Write auto-precharge starts after burst plus write recovery.
// [RL10] Precharge-all closes every bank at once, ignoring bank bits.
// [RL11] Controller turns termination off before self-refresh entry.
// [RL12] In self refresh inputs ignored; DLL off; internal refresh. Internal refresh is not modelled; O_INT_REFRESH stays low.
// [RL13] Controller may stop clock one cycle after self-refresh entry.
// [RL14] Exit by raising clock enable; only NOP until exit delay.
// [RL15] Controller holds clock enable high through read exit delay.
// [RL16] Controller refreshes once before re-entering self refresh.
// [RL17] Refresh decode; row address generated internally.
// [RL18] Refresh leaves all banks idle; controller waits cycle time.
// [RL19] At most eight refreshes postponed; gap under nine intervals.
// [RL20] Termination turned off before changing resistance.
// [RL21] Termination pin held low through whole update window.
// [RL22] Extended register 1 write updates termination bits A6,A2.
// [RL23] New termination applied within update window.
// [RL24] Chip select high makes the cycle a no-operation.
// [RL25] Open or idle state of eight banks is tracked.
module ddr2_cmd_logic #(
   parameter int BL    = 4,
   parameter int WR    = 3,
   parameter int BANKS = 8
)(
   input  wire logic        I_CLK_SYS,     // Device clock
   input  wire logic        I_RST,         // Async reset, high
   input  wire logic        I_CKE,         // Clock enable pin
   input  wire logic        I_CS_N,        // Chip select, low
   input  wire logic        I_RAS_N,       // Row strobe, low
   input  wire logic        I_CAS_N,       // Column strobe, low
   input  wire logic        I_WE_N,        // Write enable, low
   input  wire logic [2:0]  I_BA,          // Bank inputs
   input  wire logic [13:0] I_ADDR,        // Address inputs
   input  wire logic        I_ODT,         // Termination pin
   input  wire logic [2:0]  I_AL,          // Additive latency setting
   input  wire logic        I_TRACE_READY, // Trace sink ready
   output logic [7:0]       O_BANK_OPEN,   // Per-bank open state
   output logic [9:0]       O_COL,         // Last column address
   output logic             O_COL_ACCEPT,  // Column command taken
   output logic             O_SELF_REF,    // In self refresh
   output logic             O_DLL_EN,      // DLL enabled
   output logic             O_INT_REFRESH, // Refresh executed
   output logic [1:0]       O_RTT,         // Applied termination setting
   output logic             O_ODT_ON,      // Termination active
   output logic             O_TRACE_VALID, // Trace word valid
   output logic [19:0]      O_TRACE        // Bank state plus command
);
   //////////////////////////////////////////////////////////////////////////
   localparam int TMOD_CYC = `TMOD_MAX_CYC;

   typedef struct packed {
      logic [1:0]  cke_s;
      logic [1:0]  cs_s;
      logic [1:0]  ras_s;
      logic [1:0]  cas_s;
      logic [1:0]  we_s;
      logic [1:0]  odt_s;
      logic [5:0]  ba_s;
      logic [27:0] addr_s;
      logic [7:0]  open_b;
      logic [7:0]  ap_pend;
      logic [7:0][5:0] ap_cnt;
      logic [9:0]  col;
      logic        col_acc;
      ddr2_cmd_pkg::pwr_t pwr;
      logic        irefr;
      logic [1:0]  rtt_pend;
      logic [1:0]  rtt;
      logic [3:0]  mod_cnt;
   } state_t;

   state_t            st;
   state_t            next_st;
   ddr2_cmd_pkg::cmd_t cmd;
   logic              cke;
   logic              trace_push;

   function automatic ddr2_cmd_pkg::cmd_t decode(input logic cs_n,
      input logic ras_n, input logic cas_n, input logic we_n,
      input logic cke_now, input logic ap);
      ddr2_cmd_pkg::cmd_t c;
      c = ddr2_cmd_pkg::CMD_NOP;
      if (cs_n)
         c = ddr2_cmd_pkg::CMD_DESEL;                      // [RL24]
      else
         case ({ras_n, cas_n, we_n})
            3'h3: c = ddr2_cmd_pkg::CMD_ACT;
            3'h5: c = ddr2_cmd_pkg::CMD_RD;                 // [RL6]
            3'h4: c = ddr2_cmd_pkg::CMD_WR;                 // [RL7]
            3'h2: c = ap ? ddr2_cmd_pkg::CMD_PREA           // [RL10]
                         : ddr2_cmd_pkg::CMD_PRE;
            3'h1: c = cke_now ? ddr2_cmd_pkg::CMD_REF       // [RL17]
                              : ddr2_cmd_pkg::CMD_SRE;
            3'h0: c = ddr2_cmd_pkg::CMD_MRS;
            default: c = ddr2_cmd_pkg::CMD_NOP;
         endcase
      return c;
   endfunction : decode

   //////////////////////////////////////////////////////////////////////////
   // Pins pass two flops before use
   assign cke = st.cke_s[1];
   assign cmd = decode(st.cs_s[1], st.ras_s[1], st.cas_s[1], st.we_s[1],
                       cke, st.addr_s[14+`AP_BIT]);

   always_comb
   begin
      logic [2:0] b;
      b = st.ba_s[5:3];
      next_st = st;
      next_st.cke_s  = {st.cke_s[0], I_CKE};
      next_st.cs_s   = {st.cs_s[0], I_CS_N};
      next_st.ras_s  = {st.ras_s[0], I_RAS_N};
      next_st.cas_s  = {st.cas_s[0], I_CAS_N};
      next_st.we_s   = {st.we_s[0], I_WE_N};
      next_st.odt_s  = {st.odt_s[0], I_ODT};
      next_st.ba_s   = {st.ba_s[2:0], I_BA};
      next_st.addr_s = {st.addr_s[13:0], I_ADDR};
      next_st.col_acc = 1'b0;
      next_st.irefr   = 1'b0;
      // Auto-precharge countdowns
      for (int i = 0; i < BANKS; i++)
      begin
         if (st.ap_pend[i])
         begin
            if (st.ap_cnt[i] <= 6'h1)
            begin
               next_st.ap_pend[i] = 1'b0;                  // [RL8] [RL9]
               next_st.open_b[i]  = 1'b0;
            end
            else
               next_st.ap_cnt[i] = st.ap_cnt[i] - 6'h1;
         end
      end
      // Termination update window
      if (st.mod_cnt != 4'h0)
      begin
         next_st.mod_cnt = st.mod_cnt - 4'h1;
         if (st.mod_cnt == 4'h1)
            next_st.rtt = st.rtt_pend;                     // [RL23]
      end
      if (st.pwr == ddr2_cmd_pkg::ST_SELF_REF)
      begin
         // Only clock enable matters; no refresh is generated here
         if (cke)
            next_st.pwr = ddr2_cmd_pkg::ST_NORMAL;          // [RL12] [RL14]
      end
      else
         case (cmd)
            ddr2_cmd_pkg::CMD_ACT:
               if (!st.open_b[b])
                  next_st.open_b[b] = 1'b1;                // [RL1] [RL25]
            ddr2_cmd_pkg::CMD_RD, ddr2_cmd_pkg::CMD_WR:
               if (st.open_b[b] && !st.ap_pend[b])         // [RL25]
               begin
                  next_st.col_acc = 1'b1;                  // [RL1]
                  next_st.col = st.addr_s[23:14];          // [RL6] [RL7]
                  if (st.addr_s[14+`AP_BIT])
                  begin
                     next_st.ap_pend[b] = 1'b1;
                     if (cmd == ddr2_cmd_pkg::CMD_RD)
                        next_st.ap_cnt[b] = 6'(I_AL) + 6'(BL/2); // [RL8]
                     else
                        next_st.ap_cnt[b] = 6'(I_AL) + 6'(I_AL)
                                          + 6'(BL/2) + 6'(WR); // [RL9]
                  end
               end
            ddr2_cmd_pkg::CMD_PRE:
               next_st.open_b[b] = 1'b0;
            ddr2_cmd_pkg::CMD_PREA:
            begin
               next_st.open_b  = 8'h00;                     // [RL10]
               next_st.ap_pend = 8'h00;
            end
            ddr2_cmd_pkg::CMD_REF:
               if (st.open_b == 8'h00)
                  next_st.irefr = 1'b1;                    // [RL17] [RL18]
            ddr2_cmd_pkg::CMD_SRE:
               next_st.pwr = ddr2_cmd_pkg::ST_SELF_REF;    // [RL12]
            ddr2_cmd_pkg::CMD_MRS:
               if (b == `EMR1_BANK)
               begin
                  next_st.rtt_pend = {st.addr_s[14+`RTT_HI_BIT],
                                      st.addr_s[14+`RTT_LO_BIT]}; // [RL22]
                  next_st.mod_cnt  = 4'(TMOD_CYC);
               end
            default: ;
         endcase
   end

   always_ff @(posedge I_CLK_SYS or posedge I_RST)
   begin
      if (I_RST)
      begin
         st <= '0;
         st.cs_s  <= 2'h3;
         st.ras_s <= 2'h3;
         st.cas_s <= 2'h3;
         st.we_s  <= 2'h3;
         st.rtt   <= `RTT_RESET;
      end
      else
         st <= next_st;
   end

   //////////////////////////////////////////////////////////////////////////
   // Command trace buffer
   trace_if #(.W(20)) tr ();
   assign trace_push  = (cmd != ddr2_cmd_pkg::CMD_NOP)
                     && (cmd != ddr2_cmd_pkg::CMD_DESEL)
                     && (st.pwr == ddr2_cmd_pkg::ST_NORMAL);
   assign tr.in_valid  = trace_push;
   assign tr.in_data   = {8'h00, st.open_b, cmd};
   assign tr.out_ready = I_TRACE_READY;

   ddr2_trace_fifo #(.W(20), .DEPTH(8)) u_fifo (
      .i_clk (I_CLK_SYS),
      .i_rst (I_RST),
      .port  (tr.fifo)
   );

   assign O_BANK_OPEN   = st.open_b;
   assign O_COL         = st.col;
   assign O_COL_ACCEPT  = st.col_acc;
   assign O_SELF_REF    = (st.pwr == ddr2_cmd_pkg::ST_SELF_REF);
   assign O_DLL_EN      = (st.pwr != ddr2_cmd_pkg::ST_SELF_REF);   // [RL12]
   assign O_INT_REFRESH = st.irefr;
   assign O_RTT         = st.rtt;
   assign O_ODT_ON      = st.odt_s[1] && (st.mod_cnt == 4'h0)      // [RL21]
                       && (st.pwr == ddr2_cmd_pkg::ST_NORMAL);     // [RL11]
   assign O_TRACE_VALID = tr.out_valid;
   assign O_TRACE       = tr.out_data;

   //////////////////////////////////////////////////////////////////////////
   act_opens_a: assert property ( // [RL1]
      @(posedge I_CLK_SYS) disable iff (I_RST)
      (cmd == ddr2_cmd_pkg::CMD_ACT && st.pwr == ddr2_cmd_pkg::ST_NORMAL)
      |=> O_BANK_OPEN[$past(st.ba_s[5:3])])
      else $error("activate did not open bank");
   prea_closes_a: assert property ( // [RL10]
      @(posedge I_CLK_SYS) disable iff (I_RST)
      (cmd == ddr2_cmd_pkg::CMD_PREA && st.pwr == ddr2_cmd_pkg::ST_NORMAL)
      |=> O_BANK_OPEN == 8'h00)
      else $error("precharge all left bank open");
   desel_idle_a: assert property ( // [RL24]
      @(posedge I_CLK_SYS) disable iff (I_RST)
      (st.cs_s[1] && st.pwr == ddr2_cmd_pkg::ST_NORMAL && st.ap_pend == 8'h00)
      |=> $stable(O_BANK_OPEN) && !O_COL_ACCEPT)
      else $error("deselect changed state");
   sref_dll_a: assert property ( // [RL12]
      @(posedge I_CLK_SYS) disable iff (I_RST)
      O_SELF_REF |-> !O_DLL_EN && !O_ODT_ON)
      else $error("dll or odt on in self refresh");
   rd_ap_time_a: assert property ( // [RL8]
      @(posedge I_CLK_SYS) disable iff (I_RST)
      (cmd == ddr2_cmd_pkg::CMD_RD && O_COL_ACCEPT == 1'b0 && I_AL == 3'h0
       && st.addr_s[14+`AP_BIT] && st.open_b[st.ba_s[5:3]]
       && !st.ap_pend[st.ba_s[5:3]] && st.pwr == ddr2_cmd_pkg::ST_NORMAL)
      |=> ##2 !O_BANK_OPEN[$past(st.ba_s[5:3], 3)])
      else $error("read auto-precharge late");
   rtt_window_a: assert property ( // [RL21]
      @(posedge I_CLK_SYS) disable iff (I_RST)
      (st.mod_cnt != 4'h0) |-> !O_ODT_ON)
      else $error("odt on during update window");
   closed_col_a: assert property ( // [RL25]
      @(posedge I_CLK_SYS) disable iff (I_RST)
      (cmd == ddr2_cmd_pkg::CMD_RD || cmd == ddr2_cmd_pkg::CMD_WR)
      && !st.open_b[st.ba_s[5:3]] |=> !O_COL_ACCEPT)
      else $error("column command taken on closed bank");
   sref_frozen_a: assert property ( // [RL12]
      @(posedge I_CLK_SYS) disable iff (I_RST)
      (st.pwr == ddr2_cmd_pkg::ST_SELF_REF && st.ap_pend == 8'h00)
      |=> $stable(O_BANK_OPEN) && !O_COL_ACCEPT)
      else $error("command acted on in self refresh");
   ref_idle_a: assert property ( // [RL18]
      @(posedge I_CLK_SYS) disable iff (I_RST)
      O_INT_REFRESH |-> O_BANK_OPEN == 8'h00)
      else $error("bank open after refresh");
   rtt_update_a: assert property ( // [RL23]
      @(posedge I_CLK_SYS) disable iff (I_RST)
      (cmd == ddr2_cmd_pkg::CMD_MRS && st.ba_s[5:3] == `EMR1_BANK
       && st.pwr == ddr2_cmd_pkg::ST_NORMAL)
      |=> ##1 O_RTT == $past({st.addr_s[14+`RTT_HI_BIT],
                              st.addr_s[14+`RTT_LO_BIT]}, 2))
      else $error("termination setting not applied");
   wr_row_open_a: assert property ( // [RL7]
      @(posedge I_CLK_SYS) disable iff (I_RST)
      (cmd == ddr2_cmd_pkg::CMD_WR && !st.addr_s[14+`AP_BIT]
       && st.open_b[st.ba_s[5:3]] && !st.ap_pend[st.ba_s[5:3]]
       && st.pwr == ddr2_cmd_pkg::ST_NORMAL)
      |=> O_BANK_OPEN[$past(st.ba_s[5:3])])
      else $error("write closed its row");
   cov_act_rd: cover property (@(posedge I_CLK_SYS) disable iff (I_RST)
      cmd == ddr2_cmd_pkg::CMD_ACT ##1 O_COL_ACCEPT);
   cov_sref: cover property (@(posedge I_CLK_SYS) disable iff (I_RST)
      O_SELF_REF ##1 !O_SELF_REF);
   cov_mrs: cover property (@(posedge I_CLK_SYS) disable iff (I_RST)
      $changed(O_RTT));
endmodule : ddr2_cmd_logic

// ---- verification/ddr2_ctrl_model.sv ----
`timescale 1ns/100ps
module ddr2_ctrl_model #(
   parameter int XSNR = 4      // Self-refresh exit delay in clocks
)(
   input  wire logic  i_clk,   // Device clock
   output logic       o_cke,   // Clock enable
   output logic       o_cs_n,  // Chip select
   output logic       o_ras_n, // Row strobe
   output logic       o_cas_n, // Column strobe
   output logic       o_we_n,  // Write enable
   output logic [2:0] o_ba,    // Bank
   output logic [13:0] o_addr, // Address
   output logic       o_odt    // Termination pin
);
   logic sr;

   initial
   begin
      {o_cke, o_cs_n, o_ras_n, o_cas_n, o_we_n} = 5'h1F;
      o_ba   = 3'h0;
      o_addr = 14'h0000;
      o_odt  = 1'b0;
      sr     = 1'b0;
   end

   ///////////////////////////////////////////////////////////////////////////
   // One command for one cycle; the pins then keep it until idle is called
   task automatic issue(input ddr2_cmd_pkg::cmd_t c, input logic [2:0] b,
                        input logic [13:0] a);
      @(negedge i_clk);
      o_cs_n = (c == ddr2_cmd_pkg::CMD_DESEL);
      o_ba   = b;
      o_addr = a;
      case (c)
         ddr2_cmd_pkg::CMD_ACT:  {o_ras_n, o_cas_n, o_we_n} = 3'h3;
         ddr2_cmd_pkg::CMD_RD:   {o_ras_n, o_cas_n, o_we_n} = 3'h5;
         ddr2_cmd_pkg::CMD_WR:   {o_ras_n, o_cas_n, o_we_n} = 3'h4;
         ddr2_cmd_pkg::CMD_PRE:  {o_ras_n, o_cas_n, o_we_n} = 3'h2;
         ddr2_cmd_pkg::CMD_PREA: {o_ras_n, o_cas_n, o_we_n} = 3'h2;
         ddr2_cmd_pkg::CMD_REF:  {o_ras_n, o_cas_n, o_we_n} = 3'h1;
         ddr2_cmd_pkg::CMD_SRE:  {o_ras_n, o_cas_n, o_we_n} = 3'h1;
         ddr2_cmd_pkg::CMD_MRS:  {o_ras_n, o_cas_n, o_we_n} = 3'h0;
         ddr2_cmd_pkg::CMD_DESEL: {o_ras_n, o_cas_n, o_we_n} = 3'h3;
         default:                {o_ras_n, o_cas_n, o_we_n} = 3'h7;
      endcase
      if (c == ddr2_cmd_pkg::CMD_SRE)
         sr = 1'b1;
      o_cke = !sr; // Held low all through self refresh
   endtask : issue

   // No-operation cycles; address lines are don't-care so they toggle
   task automatic idle(input int n);
      repeat (n)
      begin
         @(negedge i_clk);
         {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'h7;
         o_addr = ~o_addr;
      end
   endtask : idle

   task automatic odt_set(input logic v);
      @(negedge i_clk);
      o_odt = v;
   endtask : odt_set

   // Clock never stops here, which is allowed
   task automatic sr_exit();
      @(negedge i_clk);
      o_cke = 1'b1;
      sr    = 1'b0;
      idle(XSNR); // Only NOP, clock enable high
   endtask : sr_exit
endmodule : ddr2_ctrl_model

// ---- verification/ddr2_command_function_logic_test.sv ----
`timescale 1ns/100ps
`include "ddr2_cmd_regs.svh"
module ddr2_command_function_logic_test;
   localparam int BL = 4;
   localparam int WR = 3;
   logic clk, rst, trace_ready, cke, cs_n, ras_n, cas_n, we_n, odt;
   logic [2:0] al, ba;
   logic [13:0] addr;
   logic [7:0] bank_open;
   logic [9:0] col;
   logic col_accept, self_ref, dll_en, int_refresh, odt_on, trace_valid;
   logic [1:0] rtt;
   logic [19:0] trace;
   int failures = 0, total_checks = 0, cycles = 0, acc_cnt = 0, ref_cnt = 0;

   ddr2_ctrl_model m (.i_clk(clk), .o_cke(cke), .o_cs_n(cs_n),
      .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n), .o_ba(ba),
      .o_addr(addr), .o_odt(odt));
   ddr2_cmd_logic #(.BL(BL), .WR(WR)) dut (.I_CLK_SYS(clk), .I_RST(rst),
      .I_CKE(cke), .I_CS_N(cs_n), .I_RAS_N(ras_n), .I_CAS_N(cas_n),
      .I_WE_N(we_n), .I_BA(ba), .I_ADDR(addr), .I_ODT(odt), .I_AL(al),
      .I_TRACE_READY(trace_ready), .O_BANK_OPEN(bank_open), .O_COL(col),
      .O_COL_ACCEPT(col_accept), .O_SELF_REF(self_ref), .O_DLL_EN(dll_en),
      .O_INT_REFRESH(int_refresh), .O_RTT(rtt), .O_ODT_ON(odt_on),
      .O_TRACE_VALID(trace_valid), .O_TRACE(trace));

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Pulse counters and hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (col_accept === 1'b1) acc_cnt++;
      if (int_refresh === 1'b1) ref_cnt++;
      if (cycles == 3000)
      begin
         failures++;
         conclude();
      end
   end

   task automatic check(input string what, input logic [19:0] seen,
                        input logic [19:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : conclude

   ///////////////////////////////////////////////////////////////////////////
   // Auto-precharge: still open dly-2 clocks after the accept is counted,
   // closed one clock later
   task automatic ap_case(input ddr2_cmd_pkg::cmd_t c, input logic [2:0] b,
                          input int dly, output logic [7:0] early,
                          output logic [7:0] late);
      int a0;
      a0 = acc_cnt;
      m.issue(ddr2_cmd_pkg::CMD_ACT, b, 14'h1A5C);
      m.issue(c, b, 14'h0412); // Early column access
      for (int k = 0; k < 12 && acc_cnt == a0; k++)
         m.idle(1);
      m.idle(dly - 2);
      early = bank_open;
      m.idle(1);
      late = bank_open;
   endtask : ap_case

   task automatic t_columns();
      int a0;
      check("bank_open", bank_open, 20'h0);
      check("dll_en", dll_en, 20'h1);
      check("rtt", rtt, `RTT_RESET);
      a0 = acc_cnt;
      m.issue(ddr2_cmd_pkg::CMD_ACT, 3'h2, 14'h0000);
      m.issue(ddr2_cmd_pkg::CMD_RD, 3'h2, 14'h3955);
      m.idle(5);
      check("read accept", acc_cnt, a0 + 1);
      check("read col", col, 20'h155);
      m.issue(ddr2_cmd_pkg::CMD_RD, 3'h5, 14'h0001);
      m.idle(5);
      check("closed bank read", acc_cnt, a0 + 1);
      m.issue(ddr2_cmd_pkg::CMD_WR, 3'h2, 14'h3BFF);
      m.idle(5);
      check("write accept", acc_cnt, a0 + 2);
      check("write col", col, 20'h3FF);
      check("row kept", bank_open, 20'h04);
      $display("test columns done");
   endtask : t_columns

   task automatic t_autoprecharge();
      logic [7:0] e, l;
      m.idle(1);
      m.issue(ddr2_cmd_pkg::CMD_PRE, 3'h2, 14'h0000);
      m.idle(5);
      al = 3'h5;
      ap_case(ddr2_cmd_pkg::CMD_WR, 3'h6, 2 * 5 + BL / 2 + WR, e, l);
      check("write ap open", e, 20'h40);
      check("write ap closed", l, 20'h00);
      al = 3'h2;
      ap_case(ddr2_cmd_pkg::CMD_RD, 3'h3, 2 + BL / 2, e, l);
      check("read ap open", e, 20'h08);
      check("read ap closed", l, 20'h00);
      al = 3'h0;
      ap_case(ddr2_cmd_pkg::CMD_RD, 3'h1, BL / 2, e, l);
      check("read ap0 open", e, 20'h02);
      check("read ap0 closed", l, 20'h00);
      $display("test autoprecharge done");
   endtask : t_autoprecharge

   task automatic t_banks();
      int r0;
      m.issue(ddr2_cmd_pkg::CMD_ACT, 3'h0, 14'h0000);
      m.idle(2); // Row-to-row spacing, under four per window
      m.issue(ddr2_cmd_pkg::CMD_ACT, 3'h1, 14'h0000);
      m.idle(2);
      m.issue(ddr2_cmd_pkg::CMD_ACT, 3'h7, 14'h0000);
      m.idle(5);
      check("three open", bank_open, 20'h83);
      m.issue(ddr2_cmd_pkg::CMD_PREA, 3'h5, 14'h0400);
      m.idle(6); // Precharge-all spacing before any activate
      check("all closed", bank_open, 20'h00);
      m.issue(ddr2_cmd_pkg::CMD_DESEL, 3'h6, 14'h0000);
      m.idle(5);
      check("deselect", bank_open, 20'h00);
      r0 = ref_cnt;
      m.issue(ddr2_cmd_pkg::CMD_REF, 3'h0, 14'h0000);
      m.idle(6); // Refresh cycle time respected
      check("refresh", ref_cnt, r0 + 1);
      check("idle after ref", bank_open, 20'h00);
      $display("test banks done");
   endtask : t_banks

   task automatic t_termination();
      m.odt_set(1'b1);
      m.idle(3);
      check("odt pin on", odt_on, 20'h1);
      m.odt_set(1'b0);
      m.idle(2);
      check("odt off", odt_on, 20'h0);
      m.issue(ddr2_cmd_pkg::CMD_MRS, `EMR1_BANK, 14'h0040);
      m.idle(6);
      check("rtt a6", rtt, 20'h2);
      m.issue(ddr2_cmd_pkg::CMD_MRS, 3'h0, 14'h0004);
      m.idle(6);
      check("rtt other reg", rtt, 20'h2);
      m.issue(ddr2_cmd_pkg::CMD_MRS, `EMR1_BANK, 14'h0004);
      m.idle(6);
      check("rtt a2", rtt, 20'h1);
      m.odt_set(1'b1);
      m.idle(4);
      check("odt on", odt_on, 20'h1);
      $display("test termination done");
   endtask : t_termination

   task automatic t_self_refresh();
      int r0;
      m.odt_set(1'b0);
      m.idle(4);
      m.issue(ddr2_cmd_pkg::CMD_SRE, 3'h0, 14'h0000);
      m.idle(5);
      check("in self ref", self_ref, 20'h1);
      check("dll off", dll_en, 20'h0);
      m.issue(ddr2_cmd_pkg::CMD_ACT, 3'h1, 14'h2C3A);
      m.idle(5);
      check("ignored act", bank_open, 20'h00);
      m.odt_set(1'b1);
      m.idle(3);
      check("odt ignored", odt_on, 20'h0);
      m.odt_set(1'b0); // Termination off again before exit
      m.sr_exit();
      m.idle(3);
      check("out of self ref", self_ref, 20'h0);
      check("dll on", dll_en, 20'h1);
      r0 = ref_cnt;
      m.issue(ddr2_cmd_pkg::CMD_REF, 3'h0, 14'h0000);
      m.idle(6);
      check("refresh after exit", ref_cnt, r0 + 1);
      $display("test self refresh done");
   endtask : t_self_refresh

   task automatic t_trace();
      int n;
      trace_ready = 1'b0;
      m.idle(8);
      trace_ready = 1'b1;
      m.idle(8);
      trace_ready = 1'b0;
      for (int k = 0; k < 10; k++)
         m.issue(ddr2_cmd_pkg::CMD_PREA, 3'h0, 14'h0400);
      m.idle(6);
      trace_ready = 1'b1;
      n = 0;
      for (int k = 0; k < 20; k++)
      begin
         if (trace_valid === 1'b1)
         begin
            if (n == 0)
               check("trace word", trace, 20'h00005);
            n++;
         end
         m.idle(1);
      end
      // Eight stored words plus the word held in the output register
      check("trace depth", n, 20'h9);
      $display("test trace done");
   endtask : t_trace

   initial
   begin
      rst = 1'b1;
      al = 3'h0;
      trace_ready = 1'b1;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      m.idle(3);
      t_columns();
      t_autoprecharge();
      t_banks();
      t_termination();
      t_self_refresh();
      t_trace();
      conclude();
   end
endmodule : ddr2_command_function_logic_test
